// ### hw/pbc_ctrl.v
// phy basic control register with loopback, speed, duplex and collision test logic
`timescale 1ns/10ps
`include "pbc_defs.vh"

module pbc_ctrl #(
  parameter SUPPORT_HALF = 1'b1,
  parameter SUPPORT_FULL = 1'b1,
  parameter RESET_NS = `PBC_RESET_NS
) (
  input wire clock_i,
  input wire rstn_i,
  // management register port
  input wire [`PBC_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  output wire [15:0] reg_rdata_o,
  output wire reg_ack_o,
  // loopback configuration pins
  input wire cfg_lb_valid_i,
  input wire cfg_lb_value_i,
  // negotiation engine
  input wire an_restart_ack_i,
  input wire an_speed_100_i,
  input wire an_full_duplex_i,
  // transmit side from mac
  input wire [3:0] txd_i,
  input wire tx_en_i,
  // receive side from line
  input wire [3:0] line_rxd_i,
  input wire line_rx_dv_i,
  input wire line_col_i,
  // receive side to mac
  output wire [3:0] rxd_o,
  output wire rx_dv_o,
  output wire col_o,
  // controls to the phy
  output wire phy_reset_o,
  output wire loopback_o,
  output wire line_rx_isolate_o,
  output wire power_down_o,
  output wire an_enable_o,
  output wire an_restart_o,
  output wire speed_100_o,
  output wire full_duplex_o
);

  localparam integer RST_CYC_N = (RESET_NS + `PBC_CLK_NS - 1) / `PBC_CLK_NS;
  localparam integer DEAD_CYC_N = `PBC_DEAD_NS / `PBC_CLK_NS;
  // counts cut to the counter width on purpose
  localparam [`PBC_CNT_W-1:0] RST_CYC = RST_CYC_N[`PBC_CNT_W-1:0];
  localparam [`PBC_CNT_W-1:0] DEAD_CYC = DEAD_CYC_N[`PBC_CNT_W-1:0];

  // counter step shared by the reset and dead-time timers
  function [`PBC_CNT_W-1:0] cnt_dec;
    input [`PBC_CNT_W-1:0] v;
    begin
      cnt_dec = v - `PBC_CNT_ONE;
    end
  endfunction

  // duplex bit as held for the supported modes
  function dup_fix;
    input v;
    begin
      if (SUPPORT_FULL && !SUPPORT_HALF) begin
        dup_fix = 1'b1;
      end else if (SUPPORT_HALF && !SUPPORT_FULL) begin
        dup_fix = 1'b0;
      end else begin
        dup_fix = v;
      end
    end
  endfunction

  reg state_q;
  reg [`PBC_CNT_W-1:0] rst_cnt_q;
  reg lb_q;
  reg spd_q;
  reg anen_q;
  reg pd_q;
  reg rstan_q;
  reg dup_q;
  reg colt_q;
  reg [15:0] rdata_q;
  reg ack_q;

  reg cfg_en_s1_q;
  reg cfg_en_s2_q;
  reg cfg_en_s3_q;
  reg cfg_val_s1_q;
  reg cfg_val_s2_q;
  reg cfg_val_s3_q;
  reg cfg_en_q;
  reg cfg_val_q;

  reg lb_eff_q;
  reg [`PBC_CNT_W-1:0] dead_q;
  reg [3:0] rxd_q;
  reg rx_dv_q;
  reg col_q;
  reg speed_q;
  reg fdx_q;

  wire ctrl_hit;
  wire ctrl_wr;
  wire lb_eff;
  wire [15:0] ctrl_word;
  wire rx_open;

  assign ctrl_hit = (reg_addr_i == `PBC_ADDR_CTRL);
  assign ctrl_wr = reg_wr_i && ctrl_hit;

  // reserved bits always read zero
  assign ctrl_word = {state_q, lb_q, spd_q, anen_q, pd_q, `PBC_RSV_ONE,
                      rstan_q, dup_q, colt_q, `PBC_RSV_LOW};

  // register state and phy reset sequence
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q <= `PBC_ST_RUN;
      rst_cnt_q <= `PBC_CNT_ZERO;
      lb_q <= `PBC_RV_LB;
      spd_q <= `PBC_RV_SPD;
      anen_q <= `PBC_RV_ANEN;
      pd_q <= `PBC_RV_PD;
      rstan_q <= `PBC_RV_RSTAN;
      dup_q <= dup_fix(`PBC_RV_DUP);
      colt_q <= `PBC_RV_COLT;
    end else begin
      case (state_q)
        `PBC_ST_RUN: begin
          if (an_restart_ack_i) begin
            rstan_q <= 1'b0;
          end
          if (ctrl_wr) begin
            if (reg_wdata_i[`PBC_B_RST]) begin
              state_q <= `PBC_ST_RST;
              rst_cnt_q <= RST_CYC;
              lb_q <= `PBC_RV_LB;
              spd_q <= `PBC_RV_SPD;
              anen_q <= `PBC_RV_ANEN;
              pd_q <= `PBC_RV_PD;
              rstan_q <= `PBC_RV_RSTAN;
              dup_q <= dup_fix(`PBC_RV_DUP);
              colt_q <= `PBC_RV_COLT;
            end else begin
              lb_q <= reg_wdata_i[`PBC_B_LB];
              spd_q <= reg_wdata_i[`PBC_B_SPD];
              anen_q <= reg_wdata_i[`PBC_B_ANEN];
              pd_q <= reg_wdata_i[`PBC_B_PD];
              dup_q <= dup_fix(reg_wdata_i[`PBC_B_DUP]);
              colt_q <= reg_wdata_i[`PBC_B_COLT];
              // a written zero leaves a pending restart alone
              if (reg_wdata_i[`PBC_B_RSTAN]) begin
                rstan_q <= 1'b1;
              end
            end
          end
        end
        `PBC_ST_RST: begin
          // writes are ignored while reset runs
          if (rst_cnt_q == `PBC_CNT_ONE) begin
            state_q <= `PBC_ST_RUN;
          end
          rst_cnt_q <= cnt_dec(rst_cnt_q);
        end
        default: begin
          state_q <= `PBC_ST_RUN;
        end
      endcase
    end
  end

  // register read port
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_q <= `PBC_RD_ZERO;
      ack_q <= 1'b0;
    end else begin
      ack_q <= reg_wr_i || reg_rd_i;
      if (reg_rd_i && ctrl_hit) begin
        rdata_q <= ctrl_word;
      end else if (reg_rd_i) begin
        rdata_q <= `PBC_RD_ZERO;
      end
    end
  end

  // configuration pin synchronisers
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      cfg_en_s1_q <= 1'b0;
      cfg_en_s2_q <= 1'b0;
      cfg_en_s3_q <= 1'b0;
      cfg_val_s1_q <= 1'b0;
      cfg_val_s2_q <= 1'b0;
      cfg_val_s3_q <= 1'b0;
      cfg_en_q <= 1'b0;
      cfg_val_q <= 1'b0;
    end else begin
      cfg_en_s1_q <= cfg_lb_valid_i;
      cfg_en_s2_q <= cfg_en_s1_q;
      cfg_en_s3_q <= cfg_en_s2_q;
      cfg_val_s1_q <= cfg_lb_value_i;
      cfg_val_s2_q <= cfg_val_s1_q;
      cfg_val_s3_q <= cfg_val_s2_q;
      if (cfg_en_s2_q == cfg_en_s3_q) begin
        cfg_en_q <= cfg_en_s3_q;
      end
      if (cfg_val_s2_q == cfg_val_s3_q) begin
        cfg_val_q <= cfg_val_s3_q;
      end
    end
  end

  // configuration setting wins over the register bit
  assign lb_eff = cfg_en_q ? cfg_val_q : lb_q;

  // loopback entry dead time
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      lb_eff_q <= 1'b0;
      dead_q <= `PBC_CNT_ZERO;
    end else begin
      lb_eff_q <= lb_eff;
      if (lb_eff && !lb_eff_q) begin
        dead_q <= DEAD_CYC;
      end else if (dead_q != `PBC_CNT_ZERO) begin
        dead_q <= cnt_dec(dead_q);
      end
    end
  end

  // loopback rx_dv held low until entry is seen and dead time ends, rxd follows txd at once
  assign rx_open = lb_eff_q && (dead_q == `PBC_CNT_ZERO);

  // receive path and collision
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      rxd_q <= 4'h0;
      rx_dv_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      if (lb_eff) begin
        rxd_q <= txd_i;
        rx_dv_q <= tx_en_i && rx_open;
      end else begin
        rxd_q <= line_rxd_i;
        rx_dv_q <= line_rx_dv_i;
      end
      col_q <= (colt_q && tx_en_i) || (!lb_eff && line_col_i);
    end
  end

  // resolved speed and duplex
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      speed_q <= `PBC_RV_SPD;
      fdx_q <= 1'b0;
    end else begin
      speed_q <= anen_q ? an_speed_100_i : spd_q;
      if (lb_eff) begin
        fdx_q <= 1'b1;
      end else begin
        fdx_q <= anen_q ? an_full_duplex_i : dup_q;
      end
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_ack_o = ack_q;
  assign rxd_o = rxd_q;
  assign rx_dv_o = rx_dv_q;
  assign col_o = col_q;
  assign phy_reset_o = state_q;
  assign loopback_o = lb_eff_q;
  assign line_rx_isolate_o = lb_eff_q;
  assign power_down_o = pd_q;
  assign an_enable_o = anen_q;
  assign an_restart_o = rstan_q;
  assign speed_100_o = speed_q;
  assign full_duplex_o = fdx_q;

endmodule // pbc_ctrl

// ### inc/pbc_defs.vh
// constants for the phy basic control register block
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH

// clock period in ns (40 mhz)
`define PBC_CLK_NS 25
// phy reset duration in ns, plain default
`define PBC_RESET_NS 1000
// longest receive dead time after entering loopback, ns
`define PBC_DEAD_NS 560

// management register index
`define PBC_ADDR_W 5
`define PBC_ADDR_CTRL 5'h00

// field positions
`define PBC_B_RST 15
`define PBC_B_LB 14
`define PBC_B_SPD 13
`define PBC_B_ANEN 12
`define PBC_B_PD 11
`define PBC_B_RSV10 10
`define PBC_B_RSTAN 9
`define PBC_B_DUP 8
`define PBC_B_COLT 7

// field reset values
`define PBC_RV_RST 1'b0
`define PBC_RV_LB 1'b0
`define PBC_RV_SPD 1'b1
`define PBC_RV_ANEN 1'b1
`define PBC_RV_PD 1'b0
`define PBC_RV_RSTAN 1'b0
`define PBC_RV_DUP 1'b0
`define PBC_RV_COLT 1'b0
`define PBC_RSV_LOW 7'h00
`define PBC_RSV_ONE 1'b0
`define PBC_RD_ZERO 16'h0000

// counter width and constants
`define PBC_CNT_W 8
`define PBC_CNT_ONE 8'h01
`define PBC_CNT_ZERO 8'h00

// controller states
`define PBC_ST_RUN 1'b0
`define PBC_ST_RST 1'b1

`endif

// ### sim/pbc_ctrl_properties.sv
// checker for the phy basic control register ports
`timescale 1ns/10ps
module pbc_ctrl_chk (
  input wire clock_i,
  input wire rstn_i,
  input wire [4:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [15:0] reg_wdata_i,
  input wire phy_reset_o,
  input wire loopback_o,
  input wire line_rx_isolate_o,
  input wire rx_dv_o,
  input wire [3:0] txd_i,
  input wire [3:0] rxd_o,
  input wire an_enable_o,
  input wire speed_100_o,
  input wire an_speed_100_i,
  input wire an_restart_o,
  input wire an_restart_ack_i,
  input wire power_down_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  rst_start_a: assert property (reg_wr_i && reg_addr_i == 0 && reg_wdata_i[15] && !phy_reset_o |=> phy_reset_o)
    else $error("phy reset did not start");
  rst_hold_a: assert property ($rose(phy_reset_o) |-> phy_reset_o [*4])
    else $error("phy reset too short");
  lb_iso_a: assert property (loopback_o |-> line_rx_isolate_o && rxd_o == $past(txd_i))
    else $error("line not isolated in loopback");
  dead_time_a: assert property ($rose(loopback_o) |-> !rx_dv_o [*8])
    else $error("receive valid inside dead time");
  an_speed_a: assert property ($past(rstn_i) && $past(an_enable_o) |-> speed_100_o == $past(an_speed_100_i))
    else $error("forced speed not ignored");
  rs_hold_a: assert property (an_restart_o && !an_restart_ack_i && !(reg_wr_i && reg_wdata_i[15]) |=> an_restart_o)
    else $error("restart dropped early");
  rs_clear_a: assert property (an_restart_ack_i && !(reg_wr_i && reg_wdata_i[9]) |=> !an_restart_o)
    else $error("restart not cleared");
  pd_write_a: assert property (reg_wr_i && reg_addr_i == 0 && !phy_reset_o && !reg_wdata_i[15]
    |=> power_down_o == $past(reg_wdata_i[11]))
    else $error("power down not written");
endmodule // pbc_ctrl_chk

bind pbc_ctrl pbc_ctrl_chk u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .phy_reset_o(phy_reset_o), .loopback_o(loopback_o), .rx_dv_o(rx_dv_o),
  .txd_i(txd_i), .rxd_o(rxd_o),
  .line_rx_isolate_o(line_rx_isolate_o), .an_enable_o(an_enable_o), .speed_100_o(speed_100_o),
  .an_speed_100_i(an_speed_100_i), .an_restart_o(an_restart_o), .an_restart_ack_i(an_restart_ack_i),
  .power_down_o(power_down_o));

// ### sim/pbc_host.sv
// host management model issuing register accesses
`timescale 1ns/10ps
module pbc_host (
  input wire clock_i,
  input wire [15:0] rdata_i,
  input wire ack_i,
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o
);
  logic [15:0] q;
  logic k;
  initial {addr_o, wr_o, rd_o, wdata_o} = '0;
  // one-cycle strobe, reserved bits written as zero
  task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge clock_i);
    {addr_o, wr_o, rd_o, wdata_o} = {a, w, !w, d & 16'hfb80};
    @(negedge clock_i);
    {wr_o, rd_o} = 2'b00;
    k = ack_i;
    q = rdata_i;
  endtask
endmodule // pbc_host

// ### sim/test_pbc_ctrl.sv
// self-checking bench for the phy basic control register
`timescale 1ns/10ps
module test_pbc_ctrl;
  logic clock_i = 0, rstn_i = 0, cfg_v = 0, ack_an = 0, tx_en = 0, cfg_val = 0, an_spd = 0;
  logic [3:0] txd = 4'h0;
  wire [4:0] addr;
  wire [15:0] wd, rdata;
  wire [3:0] rxd;
  wire wr, rd, ack, col, rx_dv, prst, lb, pd, rs, s100, fd;
  int errors = 0, check_count = 0, cyc = 0;
  pbc_host u_host (.clock_i(clock_i), .rdata_i(rdata), .ack_i(ack), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wd));
  pbc_ctrl #(.RESET_NS(100)) u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_ack_o(ack), .cfg_lb_valid_i(cfg_v),
    .cfg_lb_value_i(cfg_val), .an_restart_ack_i(ack_an), .an_speed_100_i(an_spd), .an_full_duplex_i(1'b0),
    .txd_i(txd), .tx_en_i(tx_en), .line_rxd_i(4'h5), .line_rx_dv_i(1'b1), .line_col_i(1'b0), .rxd_o(rxd),
    .rx_dv_o(rx_dv), .col_o(col), .phy_reset_o(prst), .loopback_o(lb), .line_rx_isolate_o(),
    .power_down_o(pd), .an_enable_o(), .an_restart_o(rs), .speed_100_o(s100), .full_duplex_o(fd));
  initial forever #12.5 clock_i = ~clock_i;
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up;
    end
  end
  task t_rst;
    u_host.acc(0, 5'h00, 16'h0000);
    chk("dflt", u_host.q, 16'h3000);
    chk("ack", u_host.k, 16'h0001);
    u_host.acc(0, 5'h01, 16'h0000);
    chk("unmapped", u_host.q, 16'h0000);
    u_host.acc(1, 5'h00, 16'h0980);
    u_host.acc(0, 5'h00, 16'h0000);
    chk("rw", u_host.q, 16'h0980);
    chk("pd", pd, 16'h0001);
    u_host.acc(1, 5'h00, 16'h8000);
    chk("busy", prst, 16'h0001);
    u_host.acc(0, 5'h00, 16'h0000);
    chk("busy rd", u_host.q, 16'hb000);
    for (int i = 0; i < 20 && u_host.q[15]; i++) u_host.acc(0, 5'h00, 16'h0000);
    chk("after", u_host.q, 16'h3000);
    $display("reset test done");
  endtask
  task t_fix;
    tx_en = 1;
    u_host.acc(1, 5'h00, 16'h0100);
    @(negedge clock_i);
    chk("spd", s100, 16'h0000);
    chk("dup", fd, 16'h0001);
    chk("no col", col, 16'h0000);
    u_host.acc(1, 5'h00, 16'h3000);
    @(negedge clock_i);
    chk("an spd", s100, 16'h0000);
    an_spd = 1;
    @(negedge clock_i);
    chk("an spd1", s100, 16'h0001);
    $display("forced test done");
  endtask
  task t_lb;
    tx_en = 1;
    txd = 4'ha;
    u_host.acc(1, 5'h00, 16'h4080);
    chk("line rxd", rxd, 16'h0005);
    repeat (30) @(negedge clock_i);
    chk("lb rxd", rxd, 16'h000a);
    chk("lb dv", rx_dv, 16'h0001);
    chk("col", col, 16'h0001);
    chk("lb dup", fd, 16'h0001);
    cfg_v = 1;
    repeat (6) @(negedge clock_i);
    chk("cfg lb", lb, 16'h0000);
    cfg_v = 0;
    tx_en = 0;
    $display("loopback test done");
  endtask
  task t_an;
    u_host.acc(1, 5'h00, 16'h1200);
    chk("rs", rs, 16'h0001);
    u_host.acc(1, 5'h00, 16'h1000);
    chk("rs hold", rs, 16'h0001);
    ack_an = 1;
    @(negedge clock_i);
    ack_an = 0;
    chk("rs clr", rs, 16'h0000);
    cfg_v = 1;
    cfg_val = 1;
    repeat (6) @(negedge clock_i);
    chk("cfg lb1", lb, 16'h0001);
    cfg_v = 0;
    cfg_val = 0;
    $display("restart test done");
  endtask
  initial begin
    repeat (8) @(negedge clock_i);
    rstn_i = 1;
    t_rst;
    t_fix;
    t_lb;
    t_an;
    wrap_up;
  end
endmodule // test_pbc_ctrl
